// ===== design/sor_regs_map.vh
`ifndef SOR_REGS_MAP_VH
`define SOR_REGS_MAP_VH

`define SOR_OFS_SOPT       8'h00
`define SOR_OFS_IDH        8'h04
`define SOR_OFS_IDL        8'h08
`define SOR_OFS_PM         8'h0c

`define SOR_SOPT_RST       8'h00
`define SOR_PM_RST         8'h1c

`define SOR_SOPT_CLKSEL    7
`define SOR_SOPT_WINDOW    6
`define SOR_SOPT_P1FE      2
`define SOR_SOPT_P2FE      1
`define SOR_SOPT_ROUTE     0

`define SOR_PM_WFLAG       7
`define SOR_PM_WACK        6
`define SOR_PM_WIRQ        5
`define SOR_PM_DRST        4
`define SOR_PM_DSTOP       3
`define SOR_PM_DEN         2
`define SOR_PM_BANDGAP_BUFFER_EN        0

`define SOR_SEQ_FIRST      8'h55
`define SOR_SEQ_SECOND     8'haa

`define SOR_RESP_OKAY      2'b00
`define SOR_RESP_SLVERR    2'b10

`define SOR_SYNC_RST       3'h0

`endif

// ===== design/sor_sys_regs.v
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sor_regs_map.vh"

module sor_sys_regs #(
    // Arbitrary neutral part code
    parameter [11:0] PART_CODE = 12'h5a3
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        srs_wr_en,
    input  wire [7:0]  srs_wr_data,
    input  wire        wdg_late_window,
    input  wire        stop_mode,
    input  wire        lv_warn_raw,
    input  wire        lv_detect_raw,
    input  wire        comparator_raw,
    output wire        watchdog_clock_select,
    output wire        watchdog_window_mode,
    output wire        wdg_service,
    output wire        wdg_window_reset,
    output wire        port_one_filter_en,
    output wire        port_two_filter_en,
    output wire        timer_ch0_capture,
    output wire        low_volt_warn_irq,
    output wire        low_volt_det_active,
    output wire        low_volt_det_reset,
    output wire        bandgap_buffer_en
);

    reg  [7:0]  aw_addr_q;
    reg         aw_have_q;
    reg  [7:0]  w_data_q;
    reg         w_strb_q;
    reg         w_have_q;
    reg         bvalid_q;
    reg  [1:0]  bresp_q;
    reg         rvalid_q;
    reg  [7:0]  rdata_q;
    reg  [1:0]  rresp_q;

    reg  [7:0]  sopt_q;
    reg         sopt_once_q;
    reg  [7:0]  pm_q;
    reg         pm_once_q;
    reg         warn_flag_q;
    reg         warn_prev_q;

    reg         seq_armed_q;
    reg         service_q;
    reg         win_reset_q;
    reg         route_q;
    reg         irq_q;
    reg         det_act_q;
    reg         det_rst_q;

    reg  [2:0]  sync1_q;
    reg  [2:0]  sync2_q;
    reg  [2:0]  sync3_q;
    reg  [2:0]  filt_q;

    wire        warn_f;
    wire        detect_f;
    wire        comp_f;
    wire        wr_go;
    wire        wr_byte;
    wire        wr_sopt;
    wire        wr_pm;
    wire        wr_mapped;
    wire        ar_take;
    wire        warn_set;
    wire        warn_clr;
    wire        det_on;
    wire [2:0]  raw_in;

    reg  [7:0]  rd_mux;
    reg         rd_hit;

    // Analog and comparator levels come from outside the clock domain
    assign raw_in = {comparator_raw, lv_detect_raw, lv_warn_raw};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    filt_q[gi]  <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    // Glitch filter: a change counts once stages two and three agree
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        filt_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    assign warn_f   = filt_q[0];
    assign detect_f = filt_q[1];
    assign comp_f   = filt_q[2];

    // Write channel: address and data are held until both are in
    // Both readies stay low while a response waits: one write in flight
    assign s_axi_awready = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready  = ~w_have_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    assign wr_go   = aw_have_q & w_have_q & ~bvalid_q;
    // Lane 0 off: the write is answered but changes nothing
    assign wr_byte = wr_go & w_strb_q;
    assign wr_sopt = wr_byte & (aw_addr_q == `SOR_OFS_SOPT);
    assign wr_pm   = wr_byte & (aw_addr_q == `SOR_OFS_PM);

    assign wr_mapped = (aw_addr_q == `SOR_OFS_SOPT) |
                       (aw_addr_q == `SOR_OFS_IDH) |
                       (aw_addr_q == `SOR_OFS_IDL) |
                       (aw_addr_q == `SOR_OFS_PM);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 8'h00;
            aw_have_q <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb_q  <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SOR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_mapped ? `SOR_RESP_OKAY : `SOR_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // System options register
    always @(posedge aclk) begin
        if (!aresetn) begin
            sopt_q      <= `SOR_SOPT_RST;
            sopt_once_q <= 1'b0;
        end else if (wr_sopt) begin
            // Free bits follow every write; only the once bits are guarded
            // write-once latch
            if (!sopt_once_q) begin
                sopt_q[`SOR_SOPT_CLKSEL] <= w_data_q[`SOR_SOPT_CLKSEL];
                sopt_q[`SOR_SOPT_WINDOW] <= w_data_q[`SOR_SOPT_WINDOW];
                sopt_once_q <= 1'b1;
            end
            sopt_q[`SOR_SOPT_P1FE] <= w_data_q[`SOR_SOPT_P1FE];
            sopt_q[`SOR_SOPT_P2FE] <= w_data_q[`SOR_SOPT_P2FE];
            sopt_q[`SOR_SOPT_ROUTE] <= w_data_q[`SOR_SOPT_ROUTE];
        end
    end

    // Power management control; flag and ack are handled apart
    always @(posedge aclk) begin
        if (!aresetn) begin
            pm_q      <= `SOR_PM_RST;
            pm_once_q <= 1'b0;
        end else if (wr_pm) begin
            // Detect enable and detect reset are guarded like the option once bits
            // write-once detect bits
            if (!pm_once_q) begin
                pm_q[`SOR_PM_DRST] <= w_data_q[`SOR_PM_DRST];
                pm_q[`SOR_PM_DEN]  <= w_data_q[`SOR_PM_DEN];
                pm_once_q <= 1'b1;
            end
            pm_q[`SOR_PM_WIRQ]  <= w_data_q[`SOR_PM_WIRQ];
            pm_q[`SOR_PM_DSTOP] <= w_data_q[`SOR_PM_DSTOP];
            pm_q[`SOR_PM_BANDGAP_BUFFER_EN]  <= w_data_q[`SOR_PM_BANDGAP_BUFFER_EN];
        end
    end

    // set on crossing
    // Sync stages reset low, so a supply already low at release
    // shows as a rising edge too.
    assign warn_set = warn_f & ~warn_prev_q;
    assign warn_clr = wr_pm & w_data_q[`SOR_PM_WACK] & ~warn_f;

    always @(posedge aclk) begin
        if (!aresetn) begin
            warn_prev_q <= 1'b0;
            warn_flag_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_f;
            // sticky warning flag
            // Set wins over clear, so a warning that meets the ack is kept
            if (warn_set) begin
                warn_flag_q <= 1'b1;
            end else if (warn_clr) begin
                warn_flag_q <= 1'b0;
            end
        end
    end

    // Service sequence tracker on reset status writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            seq_armed_q <= 1'b0;
            service_q   <= 1'b0;
            win_reset_q <= 1'b0;
        end else begin
            service_q   <= 1'b0;
            win_reset_q <= 1'b0;
            if (srs_wr_en) begin
                if (sopt_q[`SOR_SOPT_WINDOW] && !wdg_late_window) begin
                    win_reset_q <= 1'b1;
                    seq_armed_q <= 1'b0;
                end else if (srs_wr_data == `SOR_SEQ_FIRST) begin
                    seq_armed_q <= 1'b1;
                end else if (srs_wr_data == `SOR_SEQ_SECOND) begin
                    service_q   <= seq_armed_q;
                    seq_armed_q <= 1'b0;
                // Any other byte disarms, so a stray write cannot finish a pair
                end else begin
                    seq_armed_q <= 1'b0;
                end
            end
        end
    end

    assign det_on = pm_q[`SOR_PM_DEN] &
                    (~stop_mode | pm_q[`SOR_PM_DSTOP]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            route_q   <= 1'b0;
            irq_q     <= 1'b0;
            det_act_q <= 1'b0;
            det_rst_q <= 1'b0;
        end else begin
            route_q   <= sopt_q[`SOR_SOPT_ROUTE] & comp_f;
            irq_q     <= pm_q[`SOR_PM_WIRQ] & warn_flag_q;
            det_act_q <= det_on;
            // Level request; the reset controller decides when to act
            // detect reset request
            det_rst_q <= det_on & pm_q[`SOR_PM_DRST] & detect_f;
        end
    end

    assign watchdog_clock_select = sopt_q[`SOR_SOPT_CLKSEL];
    assign watchdog_window_mode  = sopt_q[`SOR_SOPT_WINDOW];
    assign wdg_service           = service_q;
    assign wdg_window_reset      = win_reset_q;
    assign port_one_filter_en    = sopt_q[`SOR_SOPT_P1FE];
    assign port_two_filter_en    = sopt_q[`SOR_SOPT_P2FE];
    assign timer_ch0_capture     = route_q;
    assign low_volt_warn_irq     = irq_q;
    assign low_volt_det_active   = det_act_q;
    assign low_volt_det_reset    = det_rst_q;
    assign bandgap_buffer_en     = pm_q[`SOR_PM_BANDGAP_BUFFER_EN];

    // Read channel: one outstanding read, data one edge after address
    // Read data is taken from the address at the accept edge
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = {24'h000000, rdata_q};
    assign s_axi_rresp   = rresp_q;
    assign ar_take       = s_axi_arvalid & ~rvalid_q;

    always @* begin
        rd_mux = 8'h00;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `SOR_OFS_SOPT: begin
                // Bits 5:3 are unimplemented and read zero
                rd_mux[`SOR_SOPT_CLKSEL] = sopt_q[`SOR_SOPT_CLKSEL];
                rd_mux[`SOR_SOPT_WINDOW] = sopt_q[`SOR_SOPT_WINDOW];
                rd_mux[`SOR_SOPT_P1FE]   = sopt_q[`SOR_SOPT_P1FE];
                rd_mux[`SOR_SOPT_P2FE]   = sopt_q[`SOR_SOPT_P2FE];
                rd_mux[`SOR_SOPT_ROUTE]  = sopt_q[`SOR_SOPT_ROUTE];
            end
            `SOR_OFS_IDH: begin
                rd_mux = {4'h0, PART_CODE[11:8]};
            end
            `SOR_OFS_IDL: begin
                rd_mux = PART_CODE[7:0];
            end
            // Ack and bit 1 read as zero; ack only acts on write
            `SOR_OFS_PM: begin
                rd_mux[`SOR_PM_WFLAG] = warn_flag_q;
                rd_mux[`SOR_PM_WIRQ]  = pm_q[`SOR_PM_WIRQ];
                rd_mux[`SOR_PM_DRST]  = pm_q[`SOR_PM_DRST];
                rd_mux[`SOR_PM_DSTOP] = pm_q[`SOR_PM_DSTOP];
                rd_mux[`SOR_PM_DEN]   = pm_q[`SOR_PM_DEN];
                rd_mux[`SOR_PM_BANDGAP_BUFFER_EN]  = pm_q[`SOR_PM_BANDGAP_BUFFER_EN];
            end
            // Unmapped reads give zero with an error response
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
            rresp_q  <= `SOR_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? `SOR_RESP_OKAY : `SOR_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== verif/sor_sys_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sor_sys_regs_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       srs_wr_en,
    input wire logic [7:0] srs_wr_data,
    input wire logic       wdg_late_window,
    input wire logic       watchdog_window_mode,
    input wire logic       watchdog_clock_select,
    input wire logic       wdg_service,
    input wire logic       wdg_window_reset,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       s_axi_arready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_early_reset: assert property (srs_wr_en && watchdog_window_mode && !wdg_late_window
        |=> wdg_window_reset) else $error("early service write gave no reset");
    a_reset_cause: assert property (wdg_window_reset |->
        $past(srs_wr_en && watchdog_window_mode && !wdg_late_window)) else $error("stray reset");
    a_no_early_svc: assert property (srs_wr_en && watchdog_window_mode && !wdg_late_window
        |=> !wdg_service) else $error("service accepted outside window");
    a_service_cause: assert property (wdg_service |->
        $past(srs_wr_en && srs_wr_data == 8'haa)) else $error("service without second byte");
    a_window_once: assert property (!$fell(watchdog_window_mode))
        else $error("window mode cleared after latch");
    a_clksel_once: assert property (!$fell(watchdog_clock_select))
        else $error("clock select cleared after latch");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response dropped early");
endmodule
bind sor_sys_regs sor_sys_regs_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .srs_wr_en(srs_wr_en), .srs_wr_data(srs_wr_data), .wdg_late_window(wdg_late_window),
    .watchdog_window_mode(watchdog_window_mode), .wdg_service(wdg_service),
    .watchdog_clock_select(watchdog_clock_select), .wdg_window_reset(wdg_window_reset),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready));
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    // Arbitrary part code, distinct from any real one
    localparam [11:0] CODE = 12'h3c9;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        srs_en, late, stop, warn, det, cmp, opt_f, pm_f, flag_e;
    logic [7:0]  awaddr, araddr, srs_d, opt_e, pm_e;
    logic [3:0]  strb;
    logic        slow;
    logic [31:0] wdata, r;
    wire         awready, wready, bvalid, arready, rvalid, wsel, wwin, svc, wrst;
    wire         f1, f2, cap, irq, dact, drst, bg;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    integer      n_errors = 0, checked = 0, cyc = 0, seed, i;
    sor_sys_regs #(.PART_CODE(CODE)) u_sor_sys_regs (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .srs_wr_en(srs_en), .srs_wr_data(srs_d), .wdg_late_window(late), .stop_mode(stop),
        .lv_warn_raw(warn), .lv_detect_raw(det), .comparator_raw(cmp),
        .watchdog_clock_select(wsel), .watchdog_window_mode(wwin), .wdg_service(svc),
        .wdg_window_reset(wrst), .port_one_filter_en(f1), .port_two_filter_en(f2),
        .timer_ch0_capture(cap), .low_volt_warn_irq(irq), .low_volt_det_active(dact),
        .low_volt_det_reset(drst), .bandgap_buffer_en(bg));
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            conclude;
        end
    end
    // Write-once bits keep their value; free bits follow the data
    function automatic [7:0] nx(input [7:0] q, d, wo, rw, input f);
        nx = f ? (q & wo) | (d & rw) : d & (wo | rw);
    endfunction
    task automatic conclude;
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input [7:0] a, d, input [1:0] er);
        logic pa, pw;
        begin
            awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= !slow;
            pa = 1; pw = 1;
            while (pa | pw) begin
                @(posedge aclk);
                if (pa && awready) begin awvalid <= 0; pa = 0; end
                if (pw && wready) begin wvalid <= 0; pw = 0; end
            end
            while (!bvalid) @(posedge aclk);
            if (slow) begin
                bready <= 1;
                @(posedge aclk);
            end
            `CHK(bresp, er)
            bready <= 0;
            @(posedge aclk);
        end
    endtask
    task automatic rd(input [7:0] a, e, input [1:0] er);
        begin
            araddr <= a; arvalid <= 1; rready <= !slow;
            @(posedge aclk);
            while (!arready) @(posedge aclk);
            arvalid <= 0;
            while (!rvalid) @(posedge aclk);
            if (slow) begin
                rready <= 1;
                @(posedge aclk);
            end
            `CHK(rdata, {24'h0, e})
            `CHK(rresp, er)
            rready <= 0;
            @(posedge aclk);
        end
    endtask
    task automatic reset_status_reg(input [7:0] d, input es, ex);
        begin
            srs_en <= 1; srs_d <= d;
            @(posedge aclk);
            srs_en <= 0;
            @(negedge aclk);
            `CHK(svc, es)
            `CHK(wrst, ex)
            @(posedge aclk);
        end
    endtask
    task automatic wopt(input [7:0] d);
        begin wr(8'h00, d, 2'b00); opt_e = nx(opt_e, d, 8'hc0, 8'h07, opt_f); opt_f = 1; end
    endtask
    task automatic wpm(input [7:0] d);
        begin
            wr(8'h0c, d, 2'b00);
            pm_e = nx(pm_e, d, 8'h14, 8'h29, pm_f); pm_f = 1;
            if (d[6] && !warn) flag_e = 0;
        end
    endtask
    task automatic rst;
        begin
            aresetn <= 0;
            repeat (5) @(posedge aclk);
            aresetn <= 1; opt_e = 0; pm_e = 8'h1c; opt_f = 0; pm_f = 0; flag_e = warn;
        end
    endtask
    // Sync chain plus output registers need about six edges
    task automatic chk_out;
        begin
            repeat (8) @(posedge aclk);
            `CHK(wsel, opt_e[7])
            `CHK(wwin, opt_e[6])
            `CHK(f1, opt_e[2])
            `CHK(f2, opt_e[1])
            `CHK(cap, opt_e[0] & cmp)
            `CHK(bg, pm_e[0])
            `CHK(dact, pm_e[2] & (!stop | pm_e[3]))
            `CHK(drst, pm_e[2] & (!stop | pm_e[3]) & pm_e[4] & det)
            `CHK(irq, pm_e[5] & flag_e)
            rd(8'h00, opt_e, 2'b00);
            rd(8'h0c, {flag_e, 1'b0, pm_e[5:0]}, 2'b00);
        end
    endtask
    initial begin
        seed = 17327;
        {awvalid, wvalid, bready, arvalid, rready, srs_en, late, stop, warn, det, cmp} = 0;
        aresetn = 0; awaddr = 0; araddr = 0; wdata = 0; srs_d = 0;
        strb = 4'h1; slow = 0;
        rst;
        rd(8'h04, {4'h0, CODE[11:8]}, 2'b00);
        wr(8'h04, 8'hff, 2'b00);
        rd(8'h04, {4'h0, CODE[11:8]}, 2'b00);
        rd(8'h08, CODE[7:0], 2'b00);
        rd(8'h10, 8'h00, 2'b10);
        wr(8'h10, 8'h5a, 2'b10);
        // Lane 0 off: no change and the once bits stay open
        strb <= 4'h0;
        wr(8'h0c, 8'h00, 2'b00);
        strb <= 4'h1;
        det <= 1;
        chk_out;
        wpm(8'h3d);
        wopt(8'h07);
        for (i = 0; i < 24; i++) begin
            r = $random(seed);
            stop <= r[8]; det <= r[9]; cmp <= r[10];
            slow = r[11];
            if (i % 2) wopt(r[7:0]);
            else wpm(r[7:0]);
            chk_out;
        end
        reset_status_reg(8'h55, 0, 0);
        reset_status_reg(8'haa, 1, 0);
        reset_status_reg(8'h55, 0, 0);
        reset_status_reg(8'h12, 0, 0);
        reset_status_reg(8'haa, 0, 0);
        rst;
        wopt(8'hc0);
        wopt(8'h00);
        wpm(8'h25);
        chk_out;
        reset_status_reg(8'h55, 0, 1);
        reset_status_reg(8'haa, 0, 1);
        late <= 1;
        reset_status_reg(8'h55, 0, 0);
        reset_status_reg(8'haa, 1, 0);
        warn <= 1; flag_e = 1;
        chk_out;
        wpm(8'h65);
        chk_out;
        warn <= 0;
        chk_out;
        wpm(8'h65);
        chk_out;
        warn <= 1;
        rst;
        chk_out;
        conclude;
    end
endmodule
`default_nettype wire
